// ==== cdd_pkg.sv ====
package cdd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_PLL = 4;
  localparam int NUM_ROW = 8;
  localparam int SEL_W = 3;
  localparam int FREQ_W = 16;
  localparam int SSC_W = 3;
  localparam int ST_W = 2;
  localparam int WORD_W = 32;
  localparam int NUM_WORD = 17;
  localparam int IDX_W = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration word addresses
  localparam logic [IDX_W-1:0] ADDR_ROW0 = 5'h00;
  localparam logic [IDX_W-1:0] ADDR_PLL0 = 5'h08;
  localparam logic [IDX_W-1:0] ADDR_GEN = 5'h10;
  localparam logic [IDX_W-1:0] ADDR_STAT = 5'h11;
  localparam logic [IDX_W-1:0] ADDR_LAST = 5'h10;

  // Setting row word: five bits per PLL, then lone, power down, bypass
  localparam int ROW_PLL_STRIDE = 5;
  localparam int ROW_FS_POS = 0;
  localparam int ROW_SSC_POS = 1;
  localparam int ROW_OUT_POS = 4;
  localparam int ROW_LONE_POS = 20;
  localparam int ROW_PD_POS = 21;
  localparam int ROW_BYP_POS = 22;

  // PLL word pair: first holds both frequencies, second spread and states
  localparam int FQA_POS = 0;
  localparam int FQB_POS = 16;
  localparam int SPRD_POS = 0;
  localparam int STA_POS = 1;
  localparam int STB_POS = 3;

  // Generic word
  localparam int LSA_POS = 0;
  localparam int LSB_POS = 2;
  localparam int DISLOW_POS = 4;
  localparam int SBUS_POS = 5;

  // Status word
  localparam int STAT_ROW_POS = 0;
  localparam int STAT_BUSY_POS = 3;
  localparam int STAT_SBUS_POS = 4;
  localparam int STAT_KEEP_POS = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Output state codes
  localparam logic [ST_W-1:0] OST_PD = 2'h0;
  localparam logic [ST_W-1:0] OST_HIZ = 2'h1;
  localparam logic [ST_W-1:0] OST_LOW = 2'h2;
  localparam logic [ST_W-1:0] OST_ACT = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Factory image and reset values
  localparam logic [FREQ_W-1:0] DEF_FREQ_A = 16'h0001;
  localparam logic [FREQ_W-1:0] DEF_FREQ_B = 16'h0002;
  localparam logic [WORD_W-1:0] DEF_ROW_EVEN = 32'h0000_0000;
  localparam logic [WORD_W-1:0] DEF_ROW_ODD = 32'h0018_4210;
  localparam logic [WORD_W-1:0] DEF_PLLA = {DEF_FREQ_B, DEF_FREQ_A};
  localparam logic [WORD_W-1:0] DEF_PLLB = 32'h0000_001a;
  localparam logic [WORD_W-1:0] DEF_GEN = 32'h0000_002d;
  localparam logic [WORD_W-1:0] RST_WORD = 32'h0000_0000;
  localparam logic [2:0] RST_DRIVE = 3'h0;

  // Factory word at one address; odd rows enable, even rows float
  function automatic logic [WORD_W-1:0] factory_word(input logic [IDX_W-1:0] idx);
    logic [WORD_W-1:0] w;
    w = RST_WORD;
    if (idx < ADDR_PLL0)
      w = idx[0] ? DEF_ROW_ODD : DEF_ROW_EVEN;
    else if (idx < ADDR_GEN)
      w = idx[0] ? DEF_PLLB : DEF_PLLA;
    else if (idx == ADDR_GEN)
      w = DEF_GEN;
    return w;
  endfunction

  // Output state to {run, oe, pd}; dis_low picks low over float when off
  function automatic logic [2:0] out_decode(input logic [ST_W-1:0] st, input logic dis_low,
                                            input logic dev_pd);
    logic [2:0] d;
    d = {1'b0, dis_low, 1'b1};
    if (!dev_pd)
    begin
      case (st)
        OST_HIZ: d = 3'h0;
        OST_LOW: d = 3'h2;
        OST_ACT: d = 3'h6;
        default: d = {1'b0, dis_low, 1'b1};
      endcase
    end
    return d;
  endfunction

endpackage

// ==== cdd_slice_if.sv ====
`timescale 1ns/1ps
interface cdd_slice_if;
  // Row selection for one PLL
  logic run;
  logic fs;
  logic [cdd_pkg::SSC_W-1:0] ssc;
  logic out_sel;
  logic dev_pd;
  logic bypass;
  logic dis_low;
  // Stored PLL configuration
  logic [cdd_pkg::FREQ_W-1:0] freq_a;
  logic [cdd_pkg::FREQ_W-1:0] freq_b;
  logic spread_down;
  logic [cdd_pkg::ST_W-1:0] state_a;
  logic [cdd_pkg::ST_W-1:0] state_b;
  // Applied settings
  logic [cdd_pkg::FREQ_W-1:0] freq;
  logic [cdd_pkg::SSC_W-1:0] ssc_amt;
  logic ssc_down;
  logic pair_run;
  logic pair_oe;
  logic pair_pd;
  logic byp;

  modport ctl (output run, fs, ssc, out_sel, dev_pd, bypass, dis_low, freq_a, freq_b,
               spread_down, state_a, state_b,
               input freq, ssc_amt, ssc_down, pair_run, pair_oe, pair_pd, byp);
  modport slice (input run, fs, ssc, out_sel, dev_pd, bypass, dis_low, freq_a, freq_b,
                 spread_down, state_a, state_b,
                 output freq, ssc_amt, ssc_down, pair_run, pair_oe, pair_pd, byp);
endinterface

// ==== cdd_pll_slice.sv ====
`timescale 1ns/1ps
module cdd_pll_slice (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Decoder side
  cdd_slice_if.slice sl
);

  typedef struct packed {
    logic [cdd_pkg::FREQ_W-1:0] freq;
    logic [cdd_pkg::SSC_W-1:0] ssc_amt;
    logic ssc_down;
    logic [2:0] drive;
    logic byp;
  } cdd_slice_type;

  cdd_slice_type st_ff;
  cdd_slice_type nxt_st;

  ////////////////////////////////////////////////////////////////////////////
  // Apply the selected row; outputs stay off until the image is loaded
  always_comb
  begin
    nxt_st = st_ff;
    if (sl.run)
    begin
      nxt_st.freq = sl.fs ? sl.freq_b : sl.freq_a;
      nxt_st.ssc_amt = sl.ssc;
      nxt_st.ssc_down = sl.spread_down;
      nxt_st.drive = cdd_pkg::out_decode(sl.out_sel ? sl.state_b : sl.state_a,
                                         sl.dis_low, sl.dev_pd);
      nxt_st.byp = sl.bypass;
    end
  end

  // State register
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign sl.freq = st_ff.freq;
  assign sl.ssc_amt = st_ff.ssc_amt;
  assign sl.ssc_down = st_ff.ssc_down;
  assign sl.pair_run = st_ff.drive[2];
  assign sl.pair_oe = st_ff.drive[1];
  assign sl.pair_pd = st_ff.drive[0];
  assign sl.byp = st_ff.byp;

endmodule

// ==== cdd_ctrl_decoder.sv ====
`timescale 1ns/1ps
module cdd_ctrl_decoder #(
  parameter int NUM_PLL = cdd_pkg::NUM_PLL
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control pins
  input wire logic ctrl_sel_lo,
  input wire logic ctrl_sel_mid,
  input wire logic ctrl_sel_hi,
  // Configuration write port from the serial engine
  input wire logic cfg_wr_en,
  input wire logic [cdd_pkg::IDX_W-1:0] cfg_wr_addr,
  input wire logic [cdd_pkg::WORD_W-1:0] cfg_wr_data,
  input wire logic cfg_commit,
  // Configuration read port
  input wire logic [cdd_pkg::IDX_W-1:0] cfg_rd_addr,
  output logic [cdd_pkg::WORD_W-1:0] cfg_rd_data,
  // Nonvolatile image state
  input wire logic nvm_keep,
  // Status
  output logic cfg_busy,
  output logic sbus_active,
  output logic [cdd_pkg::SEL_W-1:0] row_index,
  output logic row_changed,
  output logic dev_pd,
  // Lone output control
  output logic lone_output_run,
  output logic lone_output_oe,
  output logic lone_output_pd,
  // Per-PLL settings, index 0 drives pll_a_output_pair up to 3 for pll_d_output_pair
  output logic [NUM_PLL-1:0][cdd_pkg::FREQ_W-1:0] pll_freq,
  output logic [NUM_PLL-1:0][cdd_pkg::SSC_W-1:0] pll_ssc_amt,
  output logic [NUM_PLL-1:0] pll_ssc_down,
  output logic [NUM_PLL-1:0] pll_bypass,
  output logic [NUM_PLL-1:0] pair_run,
  output logic [NUM_PLL-1:0] pair_oe,
  output logic [NUM_PLL-1:0] pair_pd
);

  typedef enum logic {
    PH_LOAD,
    PH_RUN
  } cdd_phase_type;

  typedef struct packed {
    cdd_phase_type phase;
    logic [cdd_pkg::IDX_W-1:0] load_idx;
    logic [cdd_pkg::NUM_WORD-1:0][cdd_pkg::WORD_W-1:0] cfg;
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [cdd_pkg::SEL_W-1:0] row_idx;
    logic row_chg;
    logic [cdd_pkg::WORD_W-1:0] rd_data;
    logic [2:0] lone_drive;
    logic dev_pd;
  } cdd_state_type;

  cdd_state_type st_ff;
  cdd_state_type nxt_st;

  // Nonvolatile image; deliberately without reset so it survives one
  logic [cdd_pkg::WORD_W-1:0] nvm_mem [cdd_pkg::NUM_WORD];

  logic sbus;
  logic dis_low;
  logic [cdd_pkg::SEL_W-1:0] sel_now;
  logic [cdd_pkg::WORD_W-1:0] row_word;
  logic [cdd_pkg::WORD_W-1:0] gen_word;
  logic [cdd_pkg::WORD_W-1:0] stat_word;
  logic commit_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding of the live image
  assign gen_word = st_ff.cfg[cdd_pkg::ADDR_GEN];
  assign sbus = gen_word[cdd_pkg::SBUS_POS];
  assign dis_low = gen_word[cdd_pkg::DISLOW_POS];
  assign row_word = st_ff.cfg[cdd_pkg::ADDR_ROW0 + {2'b00, st_ff.row_idx}];
  assign commit_ok = cfg_commit && (st_ff.phase == PH_RUN);

  // Shared pins on the serial bus read as zero for row selection
  always_comb
  begin
    sel_now = st_ff.sync2;
    if (sbus)
    begin
      sel_now[2] = 1'b0;
      sel_now[1] = 1'b0;
    end
  end

  // Status word for read back
  always_comb
  begin
    stat_word = cdd_pkg::RST_WORD;
    stat_word[cdd_pkg::STAT_ROW_POS +: cdd_pkg::SEL_W] = st_ff.row_idx;
    stat_word[cdd_pkg::STAT_BUSY_POS] = (st_ff.phase == PH_LOAD);
    stat_word[cdd_pkg::STAT_SBUS_POS] = sbus;
    stat_word[cdd_pkg::STAT_KEEP_POS] = nvm_keep;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: image load, writes, synchroniser and row decode
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.row_chg = 1'b0;
    // Two flops on the pins; only the second one is decoded
    nxt_st.sync1 = {ctrl_sel_hi, ctrl_sel_mid, ctrl_sel_lo};
    nxt_st.sync2 = st_ff.sync1;
    case (st_ff.phase)
      PH_LOAD:
      begin
        // One word per cycle; user image only if it was reprogrammed
        if (nvm_keep)
          nxt_st.cfg[st_ff.load_idx] = nvm_mem[st_ff.load_idx];
        else
          nxt_st.cfg[st_ff.load_idx] = cdd_pkg::factory_word(st_ff.load_idx);
        nxt_st.load_idx = st_ff.load_idx + 5'h01;
        if (st_ff.load_idx == cdd_pkg::ADDR_LAST)
          nxt_st.phase = PH_RUN;
      end
      PH_RUN:
      begin
        // In-system update; writes during load are dropped
        if (cfg_wr_en && (cfg_wr_addr <= cdd_pkg::ADDR_LAST))
          nxt_st.cfg[cfg_wr_addr] = cfg_wr_data;
        // Row index follows the pins once the image is valid
        if (sel_now != st_ff.row_idx)
        begin
          nxt_st.row_idx = sel_now;
          nxt_st.row_chg = 1'b1;
        end
        // Lone output and global power down from the row
        nxt_st.dev_pd = row_word[cdd_pkg::ROW_PD_POS];
        nxt_st.lone_drive = cdd_pkg::out_decode(
          row_word[cdd_pkg::ROW_LONE_POS] ? gen_word[cdd_pkg::LSB_POS +: cdd_pkg::ST_W]
                                          : gen_word[cdd_pkg::LSA_POS +: cdd_pkg::ST_W],
          dis_low, row_word[cdd_pkg::ROW_PD_POS]);
      end
      default:
      begin
        nxt_st.phase = PH_LOAD;
      end
    endcase
    // Read back of image words and the status word
    if (cfg_rd_addr <= cdd_pkg::ADDR_LAST)
      nxt_st.rd_data = st_ff.cfg[cfg_rd_addr];
    else if (cfg_rd_addr == cdd_pkg::ADDR_STAT)
      nxt_st.rd_data = stat_word;
    else
      nxt_st.rd_data = cdd_pkg::RST_WORD;
  end

  // State register
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // Commit burns the live image; a write in the same cycle lands next time
  always_ff @(posedge mclk)
  begin
    if (commit_ok)
    begin
      for (int i = 0; i < cdd_pkg::NUM_WORD; i++)
        nvm_mem[i] <= st_ff.cfg[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One slice per PLL, each fed from its own pair of image words
  for (genvar p = 0; p < NUM_PLL; p++)
  begin : g_pll
    localparam int BASE = p * cdd_pkg::ROW_PLL_STRIDE;
    localparam logic [cdd_pkg::IDX_W-1:0] WA = cdd_pkg::ADDR_PLL0 + 5'(2 * p);
    localparam logic [cdd_pkg::IDX_W-1:0] WB = cdd_pkg::ADDR_PLL0 + 5'(2 * p + 1);

    cdd_slice_if u_if ();

    // Row fields and stored entries of this PLL
    assign u_if.run = (st_ff.phase == PH_RUN);
    assign u_if.fs = row_word[BASE + cdd_pkg::ROW_FS_POS];
    assign u_if.ssc = row_word[BASE + cdd_pkg::ROW_SSC_POS +: cdd_pkg::SSC_W];
    assign u_if.out_sel = row_word[BASE + cdd_pkg::ROW_OUT_POS];
    assign u_if.dev_pd = row_word[cdd_pkg::ROW_PD_POS];
    assign u_if.bypass = row_word[cdd_pkg::ROW_BYP_POS];
    assign u_if.dis_low = dis_low;
    assign u_if.freq_a = st_ff.cfg[WA][cdd_pkg::FQA_POS +: cdd_pkg::FREQ_W];
    assign u_if.freq_b = st_ff.cfg[WA][cdd_pkg::FQB_POS +: cdd_pkg::FREQ_W];
    assign u_if.spread_down = st_ff.cfg[WB][cdd_pkg::SPRD_POS];
    assign u_if.state_a = st_ff.cfg[WB][cdd_pkg::STA_POS +: cdd_pkg::ST_W];
    assign u_if.state_b = st_ff.cfg[WB][cdd_pkg::STB_POS +: cdd_pkg::ST_W];

    cdd_pll_slice u_slice (
      .mclk (mclk),
      .sys_rst (sys_rst),
      .sl (u_if.slice)
    );

    // Registered results out to the pins
    assign pll_freq[p] = u_if.freq;
    assign pll_ssc_amt[p] = u_if.ssc_amt;
    assign pll_ssc_down[p] = u_if.ssc_down;
    assign pll_bypass[p] = u_if.byp;
    assign pair_run[p] = u_if.pair_run;
    assign pair_oe[p] = u_if.pair_oe;
    assign pair_pd[p] = u_if.pair_pd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Top-level status and lone output
  assign cfg_rd_data = st_ff.rd_data;
  assign cfg_busy = (st_ff.phase == PH_LOAD);
  assign sbus_active = sbus;
  assign row_index = st_ff.row_idx;
  assign row_changed = st_ff.row_chg;
  assign dev_pd = st_ff.dev_pd;
  assign lone_output_run = st_ff.lone_drive[2];
  assign lone_output_oe = st_ff.lone_drive[1];
  assign lone_output_pd = st_ff.lone_drive[0];

endmodule

// ==== cdd_ctrl_decoder_props.sv ====
`timescale 1ns/1ps
module cdd_ctrl_decoder_props #(
  parameter int NUM_PLL = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Pins and configuration port
  input wire logic ctrl_sel_lo,
  input wire logic ctrl_sel_mid,
  input wire logic ctrl_sel_hi,
  input wire logic cfg_wr_en,
  input wire logic [4:0] cfg_wr_addr,
  input wire logic [31:0] cfg_wr_data,
  input wire logic [4:0] cfg_rd_addr,
  input wire logic [31:0] cfg_rd_data,
  // Status and drive
  input wire logic cfg_busy,
  input wire logic sbus_active,
  input wire logic [2:0] row_index,
  input wire logic row_changed,
  input wire logic dev_pd,
  input wire logic lone_output_run,
  input wire logic lone_output_oe,
  input wire logic lone_output_pd,
  input wire logic [NUM_PLL-1:0] pll_bypass,
  input wire logic [NUM_PLL-1:0] pair_run,
  input wire logic [NUM_PLL-1:0] pair_oe,
  input wire logic [NUM_PLL-1:0] pair_pd
);
  logic [2:0] pins;
  // Pins gathered upper first
  assign pins = {ctrl_sel_hi, ctrl_sel_mid, ctrl_sel_lo};
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  //////////////////////////////////////////////////////////////////////////////
  // Five still cycles cover both sync flops and the row register, with margin
  a_row_from_pins: assert property ((!sbus_active && !cfg_busy && $stable(pins))[*5] |-> row_index == pins)
    else $error("row index does not follow the pins");
  a_row_bus_mask: assert property ((sbus_active && !cfg_busy && $stable(pins))[*5] |-> row_index == {2'b00, ctrl_sel_lo})
    else $error("masked pins leak into the row index");
  a_change_pulse: assert property (row_changed == $changed(row_index))
    else $error("row change pulse wrong");
  a_pd_forces_off: assert property (dev_pd && $past(dev_pd) |-> pair_run == '0 && pair_pd == '1 && lone_output_pd && !lone_output_run)
    else $error("device power down leaves a driver on");
  a_drive_legal: assert property ((pair_run & (~pair_oe | pair_pd)) == '0 && !(lone_output_run && (!lone_output_oe || lone_output_pd)))
    else $error("illegal output drive combination");
  a_load_length: assert property ($fell(sys_rst) |-> cfg_busy ##[14:19] !cfg_busy)
    else $error("image load length wrong");
  a_idle_in_load: assert property (cfg_busy |-> pair_run == '0 && !lone_output_run && !row_changed)
    else $error("outputs move during load");
  a_write_readback: assert property ((cfg_wr_en && !cfg_busy && cfg_wr_addr <= 5'h10 && cfg_rd_addr == cfg_wr_addr)
    ##1 (!cfg_wr_en && $stable(cfg_rd_addr)) |=> cfg_rd_data == $past(cfg_wr_data, 2))
    else $error("written word not read back");

  // Main scenarios reached
  c_row_move: cover property (row_changed && !sbus_active);
  c_dev_pd: cover property (dev_pd);
  c_bypass: cover property (pll_bypass == '1);
endmodule

bind cdd_ctrl_decoder cdd_ctrl_decoder_props #(.NUM_PLL(NUM_PLL)) u_props (.mclk, .sys_rst, .ctrl_sel_lo, .ctrl_sel_mid,
  .ctrl_sel_hi, .cfg_wr_en, .cfg_wr_addr, .cfg_wr_data, .cfg_rd_addr, .cfg_rd_data, .cfg_busy, .sbus_active,
  .row_index, .row_changed, .dev_pd, .lone_output_run, .lone_output_oe, .lone_output_pd, .pll_bypass, .pair_run,
  .pair_oe, .pair_pd);

// ==== cdd_pin_board.sv ====
`timescale 1ns/1ps
module cdd_pin_board (
  // Clock
  input wire logic mclk,
  // Requested row
  input wire logic [2:0] want,
  // Control pins
  output logic ctrl_sel_lo,
  output logic ctrl_sel_mid,
  output logic ctrl_sel_hi
);
  logic [2:0] pins_ff = 3'h0;
  // Board moves pins on the falling edge only, far from the sampling edge
  always @(negedge mclk)
    pins_ff <= want;
  assign {ctrl_sel_hi, ctrl_sel_mid, ctrl_sel_lo} = pins_ff;
endmodule

// ==== cdd_ctrl_decoder_tb.sv ====
`timescale 1ns/1ps
module cdd_ctrl_decoder_tb;
  // Stimulus
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic cfg_wr_en = 1'b0;
  logic [4:0] cfg_wr_addr = 5'h00;
  logic [31:0] cfg_wr_data = 32'h0000_0000;
  logic cfg_commit = 1'b0;
  logic [4:0] cfg_rd_addr = 5'h00;
  logic nvm_keep = 1'b0;
  logic [2:0] want = 3'h0;
  // Observed
  logic ctrl_sel_lo, ctrl_sel_mid, ctrl_sel_hi, cfg_busy, sbus_active, row_changed, dev_pd;
  logic lone_output_run, lone_output_oe, lone_output_pd;
  logic [31:0] cfg_rd_data;
  logic [2:0] row_index;
  logic [3:0][15:0] pll_freq;
  logic [3:0][2:0] pll_ssc_amt;
  logic [3:0] pll_ssc_down, pll_bypass, pair_run, pair_oe, pair_pd;
  int fails = 0;
  int checks = 0;

  cdd_ctrl_decoder uut (.mclk, .sys_rst, .ctrl_sel_lo, .ctrl_sel_mid, .ctrl_sel_hi, .cfg_wr_en, .cfg_wr_addr,
    .cfg_wr_data, .cfg_commit, .cfg_rd_addr, .cfg_rd_data, .nvm_keep, .cfg_busy, .sbus_active, .row_index,
    .row_changed, .dev_pd, .lone_output_run, .lone_output_oe, .lone_output_pd, .pll_freq, .pll_ssc_amt,
    .pll_ssc_down, .pll_bypass, .pair_run, .pair_oe, .pair_pd);
  cdd_pin_board board (.mclk, .want, .ctrl_sel_lo, .ctrl_sel_mid, .ctrl_sel_hi);

  initial forever #20 mclk = ~mclk;

  //////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task complete_run;
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read data is registered, so look one cycle after the address
  task rd(input logic [4:0] a, input logic [31:0] e);
    @(negedge mclk);
    cfg_rd_addr = a;
    @(negedge mclk);
    cmp(cfg_rd_data, e);
  endtask

  task wr(input logic [4:0] a, input logic [31:0] d);
    @(negedge mclk);
    cfg_wr_en = 1'b1;
    cfg_wr_addr = a;
    cfg_wr_data = d;
    cfg_rd_addr = a;
    @(negedge mclk);
    cfg_wr_en = 1'b0;
    rd(a, d);
  endtask

  // Bounded wait for the image load
  task do_reset;
    sys_rst = 1'b1;
    repeat (6) @(negedge mclk);
    sys_rst = 1'b0;
    for (int i = 0; i < 40 && cfg_busy !== 1'b0; i++)
      @(negedge mclk);
    cmp(32'(cfg_busy), 32'h0);
  endtask

  // Expected {run, oe, pd}; power down drives low only when asked
  function automatic logic [2:0] drv(input logic [1:0] st, input logic dl, input logic pd);
    if (pd || st == cdd_pkg::OST_PD)
      return {1'b0, dl, 1'b1};
    if (st == cdd_pkg::OST_HIZ)
      return 3'h0;
    return (st == cdd_pkg::OST_LOW) ? 3'h2 : 3'h6;
  endfunction

  // Row r: frequency r[0], spread r, output r[1], lone r[2]; row 7 powers down, row 5 bypasses
  function automatic logic [31:0] rw(input int r);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int n = 0; n < 4; n++)
      w[5*n +: 5] = {r[1], r[2:0], r[0]};
    w[22:20] = {r == 5, r == 7, r[2]};
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_factory;
    rd(5'h10, cdd_pkg::DEF_GEN);
    rd(5'h11, 32'h0000_0010);
    want = 3'h7;
    repeat (8) @(negedge mclk);
    cmp(32'(row_index), 32'h1);
    cmp(32'({pair_run, lone_output_run}), 32'h1f);
    want = 3'h6;
    repeat (8) @(negedge mclk);
    cmp(32'({pair_run, pair_oe, lone_output_oe}), 32'h0);
  endtask

  // Extreme frequencies, every state code, serial bus handed back to pins last
  task t_program;
    for (int n = 0; n < 4; n++)
    begin
      wr(5'(8 + 2 * n), {14'h3fff, n[1:0], 14'h0000, n[1:0]});
      wr(5'(9 + 2 * n), {27'h0, ~n[1:0], n[1:0], n[0]});
    end
    for (int r = 0; r < 8; r++)
      wr(5'(r), rw(r));
    wr(5'h10, 32'h0000_001c);
    cmp(32'(sbus_active), 32'h0);
    rd(5'h1f, 32'h0000_0000);
  endtask

  task t_sweep;
    logic [1:0] st;
    for (int r = 0; r < 8; r++)
    begin
      want = 3'(r);
      repeat (8) @(negedge mclk);
      cmp(32'(row_index), 32'(r));
      cmp(32'(dev_pd), 32'(r == 7));
      cmp(32'({lone_output_run, lone_output_oe, lone_output_pd}), 32'(drv({2{r[2]}}, 1'b1, r == 7)));
      for (int n = 0; n < 4; n++)
      begin
        st = r[1] ? ~n[1:0] : n[1:0];
        cmp(32'(pll_freq[n]), 32'({r[0] ? 14'h3fff : 14'h0000, n[1:0]}));
        cmp(32'({pll_ssc_down[n], pll_ssc_amt[n]}), 32'({n[0], r[2:0]}));
        cmp(32'(pll_bypass[n]), 32'(r == 5));
        cmp(32'({pair_run[n], pair_oe[n], pair_pd[n]}), 32'(drv(st, 1'b1, r == 7)));
      end
    end
    // Row 7 still selected; with the low-drive bit clear, powered-down drivers float
    wr(5'h10, 32'h0000_000c);
    cmp(32'({pair_run, pair_oe, pair_pd}), 32'h0000_000f);
    cmp(32'({lone_output_run, lone_output_oe, lone_output_pd}), 32'h0000_0001);
    wr(5'h10, 32'h0000_001c);
  endtask

  // Stored image is used at load only while marked reprogrammed
  task t_nvm;
    @(negedge mclk);
    cfg_commit = 1'b1;
    @(negedge mclk);
    cfg_commit = 1'b0;
    nvm_keep = 1'b1;
    do_reset;
    rd(5'h10, 32'h0000_001c);
    rd(5'h04, rw(4));
    nvm_keep = 1'b0;
    do_reset;
    rd(5'h10, cdd_pkg::DEF_GEN);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    do_reset;
    t_factory;
    t_program;
    t_sweep;
    t_nvm;
    complete_run;
  end

  // Watchdog, far beyond the few hundred cycles the run needs
  initial
  begin
    #(40 * 5000);
    fails++;
    complete_run;
  end
endmodule
